//--- rtl/pcb_pkg.sv
// Register map, reset patterns and sizes of the port control bank
//
// Behaviour
// [RQ1] Analog-output pins of port 14 reset to input, no pull-up.
// [RQ2] Each pin: input, pulled-up input, latch output or alternate output.
// [RQ3] Port 12 is input only, no direction or alternate register.
// [RQ4] Every output latch resets to zero on any reset source.
// [RQ5] Data read returns the synchronised pin level for input bits.
// [RQ6] Data read returns the latch for plain output bits.
// [RQ7] A data write updates every latch bit, input or output.
// [RQ8] Port 12 data register is read only and returns pin levels.
// [RQ9] Read-modify-write stores sampled pin levels into input-bit latches.
// [RQ10] Direction registers reset to zero, all pins input; with the strap low, ports 0 to 4 load the bus pattern instead.
// [RQ11] Strap low at reset makes external bus pins outputs.
// [RQ12] Ports 0 to 4 reset to zero or bus pattern by strap.
// [RQ13] Direction bit zero means input, one means output.
// [RQ14] Unimplemented bit positions store nothing and read zero.
// [RQ15] Alternate bit: pull-up when input, alternate source when output.
// [RQ16] Alternate output without an assigned function drives zero.
// [RQ17] Data read of an alternate output bit returns alternate data.
// [RQ18] Alternate registers reset to zero except bus pins, strap low.
// [RQ19] All reset sources merge into one synchronous internal reset.
// [RQ20] Output enable equals direction bit; data from latch or alternate.
package pcb_pkg;

  localparam int PCB_NPORT = 14;
  localparam int PCB_AW    = 16;
  localparam int PCB_DW    = 8;

  typedef logic [PCB_DW-1:0] pcb_byte_t;

  // Index order: ports 0..11, then 14, 15
  localparam logic [15:0] PCB_LATCH_ADDR [PCB_NPORT] = '{
    16'h0018, 16'h0019, 16'h001A, 16'h001B, 16'h001C, 16'h001D,
    16'h001E, 16'h001F, 16'h00B8, 16'h00B9, 16'h00BA, 16'h00BB,
    16'h00BE, 16'h00BF};
  localparam logic [15:0] PCB_DIR_ADDR [PCB_NPORT] = '{
    16'h0020, 16'h0021, 16'h0022, 16'h0023, 16'h0024, 16'h0025,
    16'h0026, 16'h0027, 16'h00C0, 16'h00C1, 16'h00C2, 16'h00C3,
    16'h00C4, 16'h00C5};
  localparam logic [15:0] PCB_ALT_ADDR [PCB_NPORT] = '{
    16'h0028, 16'h0029, 16'h002A, 16'h002B, 16'h002C, 16'h002D,
    16'h002E, 16'h002F, 16'h00C8, 16'h00C9, 16'h00CA, 16'h00CB,
    16'h00C6, 16'h00C7};
  localparam logic [15:0] PCB_ANALOG_ADDR = 16'h00BC;

  localparam pcb_byte_t PCB_LATCH_RST = 8'h00;
  localparam pcb_byte_t PCB_DIR_RST   = 8'h00;
  localparam pcb_byte_t PCB_ALT_RST   = 8'h00;

  // Reset patterns with the external access strap low
  localparam pcb_byte_t PCB_DIR_EXT [PCB_NPORT] = '{
    8'hFF, 8'hFF, 8'h0F, 8'h02, 8'hFF, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam pcb_byte_t PCB_ALT_EXT [PCB_NPORT] = '{
    8'hFF, 8'hFF, 8'h0F, 8'h03, 8'hFF, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Implemented bits per port
  localparam pcb_byte_t PCB_IMPL [PCB_NPORT] = '{
    8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF};

  localparam int        PCB_ANALOG_OUT_PORT = 12;
  localparam pcb_byte_t PCB_ANALOG_OUT_BITS = 8'hC0;

endpackage

//--- rtl/pcb_pad_cell.sv
// Pin synchroniser and pad drive for one eight-bit port
`timescale 1ns/1ps
`default_nettype none
module pcb_pad_cell #(
  parameter logic [7:0] ALT_PRESENT = 8'hFF
) (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic [7:0] pad_in,
  input  wire logic [7:0] latch,
  input  wire logic [7:0] dir,
  input  wire logic [7:0] alt_sel,
  input  wire logic [7:0] alt_src,
  output logic      [7:0] pin_level_q,
  output logic      [7:0] pad_out_q,
  output logic      [7:0] pad_oe_q,
  output logic      [7:0] pad_pullup_q,
  output logic      [7:0] read_data
);

  logic [7:0] meta_q;
  wire  [7:0] alt_gated;
  wire  [7:0] drive_d;

  assign alt_gated = alt_src & ALT_PRESENT; // RQ16
  assign drive_d   = (alt_sel & alt_gated) | (~alt_sel & latch); // RQ20
  // RQ5 RQ6 RQ17
  assign read_data = (~dir & pin_level_q) | (dir & drive_d);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q       <= 8'h00;
      pin_level_q  <= 8'h00;
      pad_out_q    <= 8'h00;
      pad_oe_q     <= 8'h00;
      pad_pullup_q <= 8'h00;
    end else if (clk_en) begin
      meta_q       <= pad_in;
      pin_level_q  <= meta_q;
      pad_out_q    <= drive_d;
      pad_oe_q     <= dir; // RQ13 RQ20
      pad_pullup_q <= ~dir & alt_sel; // RQ2 RQ15
    end
  end

endmodule
`default_nettype wire

//--- rtl/pcb_port_bank.sv
// Port control bank: special function registers, reset merge, pads
`timescale 1ns/1ps
`default_nettype none
module pcb_port_bank #(
  parameter logic [pcb_pkg::PCB_NPORT-1:0][7:0] ALT_PRESENT = '1
) (
  input  wire logic                         core_clk,
  input  wire logic                         arst_n,
  input  wire logic                         clk_en,
  input  wire logic                         reset_pin_n,
  input  wire logic                         break_instruction,
  input  wire logic                         watchdog_overflow,
  input  wire logic                         opcode_trap,
  input  wire logic                         external_access_strap_n,
  input  wire logic [15:0]                  sfr_addr,
  input  wire logic                         sfr_wr,
  input  wire logic                         sfr_rd,
  input  wire logic [7:0]                   sfr_wdata,
  output logic      [7:0]                   sfr_rdata_q,
  output logic                              sfr_rd_valid_q,
  output logic                              sys_reset_q,
  input  wire logic [pcb_pkg::PCB_NPORT-1:0][7:0] pad_in,
  output wire logic [pcb_pkg::PCB_NPORT-1:0][7:0] pad_out,
  output wire logic [pcb_pkg::PCB_NPORT-1:0][7:0] pad_oe,
  output wire logic [pcb_pkg::PCB_NPORT-1:0][7:0] pad_pullup,
  input  wire logic [pcb_pkg::PCB_NPORT-1:0][7:0] alt_out_data,
  output wire logic [pcb_pkg::PCB_NPORT-1:0][7:0] alt_in_data,
  input  wire logic [7:0]                   analog_pad_in
);

  localparam int NP = pcb_pkg::PCB_NPORT;

  logic [1:0] rst_pin_sync_q;
  logic [1:0] strap_sync_q;
  logic [7:0] analog_meta_q;
  logic [7:0] analog_level_q;

  wire reset_req;
  wire ea_low;
  wire hit_analog;
  wire run;

  wire  [NP-1:0][7:0] latch_w;
  wire  [NP-1:0][7:0] dir_w;
  wire  [NP-1:0][7:0] alt_w;
  wire  [NP-1:0][7:0] cell_rd_w;
  wire  [NP-1:0]      hit_latch_w;
  wire  [NP-1:0]      hit_dir_w;
  wire  [NP-1:0]      hit_alt_w;
  logic [7:0]         rdata_d;

  // Pins pass two flops before use
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_pin_sync_q <= 2'b00;
      strap_sync_q   <= 2'b11;
      analog_meta_q  <= 8'h00;
      analog_level_q <= 8'h00;
    end else if (clk_en) begin
      rst_pin_sync_q <= {rst_pin_sync_q[0], reset_pin_n};
      strap_sync_q   <= {strap_sync_q[0], external_access_strap_n};
      analog_meta_q  <= analog_pad_in; // RQ3
      analog_level_q <= analog_meta_q;
    end
  end

  // Break, watchdog and trap share this clock, so they skip the sync
  // One internal reset from all four sources
  assign reset_req = ~rst_pin_sync_q[1] | break_instruction
                   | watchdog_overflow | opcode_trap; // RQ19

  // Reset held out of asynchronous reset until the pin sync settles
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_reset_q <= 1'b1;
    end else if (clk_en) begin
      sys_reset_q <= reset_req; // RQ19
    end
  end

  // Strap is sampled on every cycle of the internal reset
  assign ea_low     = ~strap_sync_q[1]; // RQ11 RQ12
  assign run        = clk_en & ~sys_reset_q;
  assign hit_analog = sfr_addr == pcb_pkg::PCB_ANALOG_ADDR;

  for (genvar p = 0; p < NP; p++) begin : g_port
    localparam logic [7:0] IMPL = pcb_pkg::PCB_IMPL[p];

    logic [7:0] latch_q;
    logic [7:0] dir_q;
    logic [7:0] alt_q;
    wire  [7:0] dir_init;
    wire  [7:0] alt_init;
    wire  [7:0] wmask;

    assign hit_latch_w[p] = sfr_addr == pcb_pkg::PCB_LATCH_ADDR[p];
    assign hit_dir_w[p]   = sfr_addr == pcb_pkg::PCB_DIR_ADDR[p];
    assign hit_alt_w[p]   = sfr_addr == pcb_pkg::PCB_ALT_ADDR[p];
    assign wmask          = sfr_wdata & IMPL; // RQ14

    // RQ12 RQ18
    assign dir_init = ea_low ? pcb_pkg::PCB_DIR_EXT[p]
                             : pcb_pkg::PCB_DIR_RST;
    assign alt_init = ea_low ? pcb_pkg::PCB_ALT_EXT[p]
                             : pcb_pkg::PCB_ALT_RST;

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        latch_q <= pcb_pkg::PCB_LATCH_RST;
        dir_q   <= pcb_pkg::PCB_DIR_RST;
        alt_q   <= pcb_pkg::PCB_ALT_RST;
      end else if (clk_en) begin
        if (sys_reset_q) begin
          latch_q <= pcb_pkg::PCB_LATCH_RST; // RQ4
          dir_q   <= dir_init & IMPL; // RQ1 RQ10 RQ11
          alt_q   <= alt_init & IMPL; // RQ1 RQ18
        end else if (sfr_wr) begin
          // Implemented bits stored, input bits too; a read-modify-write gives them the pin level
          if (hit_latch_w[p]) latch_q <= wmask; // RQ7 RQ9
          if (hit_dir_w[p])   dir_q   <= wmask; // RQ13
          if (hit_alt_w[p])   alt_q   <= wmask; // RQ15
        end
      end
    end

    assign latch_w[p] = latch_q;
    assign dir_w[p]   = dir_q;
    assign alt_w[p]   = alt_q;

    pcb_pad_cell #(
      .ALT_PRESENT (ALT_PRESENT[p])
    ) u_cell (
      .core_clk     (core_clk),
      .arst_n       (arst_n),
      .clk_en       (clk_en),
      .pad_in       (pad_in[p]),
      .latch        (latch_q),
      .dir          (dir_q),
      .alt_sel      (alt_q),
      .alt_src      (alt_out_data[p]),
      .pin_level_q  (alt_in_data[p]),
      .pad_out_q    (pad_out[p]),
      .pad_oe_q     (pad_oe[p]),
      .pad_pullup_q (pad_pullup[p]),
      .read_data    (cell_rd_w[p])
    );
  end

  // Read mux; unmapped addresses return zero
  always_comb begin
    rdata_d = hit_analog ? analog_level_q : 8'h00; // RQ8
    for (int i = 0; i < NP; i++) begin
      if (hit_latch_w[i])
        rdata_d = rdata_d | (cell_rd_w[i] & pcb_pkg::PCB_IMPL[i]);
      if (hit_dir_w[i])
        rdata_d = rdata_d | dir_w[i];
      if (hit_alt_w[i])
        rdata_d = rdata_d | alt_w[i];
    end
  end

  // Read answer one cycle after the strobe, held until the next read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata_q    <= 8'h00;
      sfr_rd_valid_q <= 1'b0;
    end else if (clk_en) begin
      sfr_rd_valid_q <= sfr_rd;
      if (sfr_rd) sfr_rdata_q <= rdata_d; // RQ5 RQ6 RQ8 RQ17
    end
  end

  // Checks; they sleep while the asynchronous reset is low
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_src_reset;
    clk_en && (break_instruction || watchdog_overflow || opcode_trap);
  endsequence

  sequence s_reset_cycle;
    clk_en && sys_reset_q;
  endsequence

  sequence s_wr_latch0;
    run && sfr_wr && hit_latch_w[0];
  endsequence

  sequence s_rd_latch0;
    clk_en && sfr_rd && hit_latch_w[0];
  endsequence

  // Any enabled read, whatever the address
  sequence s_rd_any;
    clk_en && sfr_rd;
  endsequence

  // Reset pin seen low past its synchroniser
  sequence s_pin_reset;
    clk_en && !rst_pin_sync_q[1];
  endsequence

  AST_RESET_MERGE: assert property ( // RQ19
    s_src_reset |=> sys_reset_q)
    else $error("reset source did not raise internal reset");

  AST_RESET_PIN: assert property ( // RQ19
    s_pin_reset |=> sys_reset_q)
    else $error("reset pin did not raise internal reset");

  AST_LATCH_RESET: assert property ( // RQ4
    s_reset_cycle |=> latch_w == '0)
    else $error("latch not zero after reset cycle");

  AST_DIR_RESET_HIGH: assert property ( // RQ10
    s_reset_cycle ##0 !ea_low |=> dir_w == '0 && alt_w == '0)
    else $error("direction or alternate not zero, strap high");

  AST_EXT_PATTERN: assert property ( // RQ11
    s_reset_cycle ##0 ea_low |=>
      dir_w[0] == pcb_pkg::PCB_DIR_EXT[0] &&
      dir_w[3] == pcb_pkg::PCB_DIR_EXT[3] &&
      alt_w[2] == pcb_pkg::PCB_ALT_EXT[2] &&
      alt_w[3] == pcb_pkg::PCB_ALT_EXT[3] &&
      dir_w[5] == 8'h00)
    else $error("external bus reset pattern wrong");

  AST_EXT_PATTERN_B: assert property ( // RQ12
    s_reset_cycle ##0 ea_low |=>
      dir_w[1] == pcb_pkg::PCB_DIR_EXT[1] &&
      dir_w[2] == pcb_pkg::PCB_DIR_EXT[2] &&
      dir_w[4] == pcb_pkg::PCB_DIR_EXT[4] &&
      alt_w[0] == pcb_pkg::PCB_ALT_EXT[0] &&
      alt_w[1] == pcb_pkg::PCB_ALT_EXT[1] &&
      alt_w[4] == pcb_pkg::PCB_ALT_EXT[4])
    else $error("external bus reset pattern incomplete");

  AST_ANALOG_OUT_RESET: assert property ( // RQ1
    s_reset_cycle |=>
      (dir_w[pcb_pkg::PCB_ANALOG_OUT_PORT] &
       pcb_pkg::PCB_ANALOG_OUT_BITS) == 8'h00 &&
      (alt_w[pcb_pkg::PCB_ANALOG_OUT_PORT] &
       pcb_pkg::PCB_ANALOG_OUT_BITS) == 8'h00)
    else $error("analog output pins not input after reset");

  AST_WRITE_ALL_BITS: assert property ( // RQ7
    s_wr_latch0 |=> latch_w[0] == $past(sfr_wdata))
    else $error("latch write lost bits");

  AST_READ_PIN: assert property ( // RQ5
    s_rd_latch0 ##0 dir_w[0] == 8'h00 |=>
      sfr_rd_valid_q && sfr_rdata_q == $past(alt_in_data[0]))
    else $error("input bit did not read pin level");

  AST_READ_LATCH: assert property ( // RQ6
    s_rd_latch0 ##0 dir_w[0] == 8'hFF ##0 alt_w[0] == 8'h00 |=>
      sfr_rdata_q == $past(latch_w[0]))
    else $error("output bit did not read latch");

  AST_READ_ALT: assert property ( // RQ17
    s_rd_latch0 ##0 dir_w[0] == 8'hFF ##0 alt_w[0] == 8'hFF |=>
      sfr_rdata_q == $past(alt_out_data[0] & ALT_PRESENT[0]))
    else $error("alternate output bit did not read source");

  AST_ANALOG_RO: assert property ( // RQ8
    run && sfr_wr && hit_analog |=>
      $stable(latch_w) && $stable(dir_w) && $stable(alt_w))
    else $error("write to analog port changed a register");

  AST_OE_FOLLOWS_DIR: assert property ( // RQ20
    clk_en ##1 clk_en |=> pad_oe == $past(dir_w))
    else $error("output enable not following direction");

  AST_PULLUP: assert property ( // RQ15
    clk_en |=> pad_pullup == $past(~dir_w & alt_w))
    else $error("pull-up not input with alternate bit");

  AST_NO_ALT_ZERO: assert property ( // RQ16
    clk_en |=> (pad_out & $past(alt_w & ~ALT_PRESENT)) == '0)
    else $error("unassigned alternate output not zero");

  AST_PULLUP_NOT_DRIVEN: assert property ( // RQ15
    clk_en |=> (pad_pullup & pad_oe) == '0)
    else $error("pull-up enabled on a driven pin");

  AST_PAD_LATCH: assert property ( // RQ20
    clk_en && dir_w[5] == 8'hFF && alt_w[5] == 8'h00 |=>
      pad_out[5] == $past(latch_w[5]))
    else $error("pad not driven from latch");

  AST_READ_VALID: assert property ( // RQ5
    s_rd_any |=> sfr_rd_valid_q)
    else $error("read strobe not answered");

  AST_VALID_PULSE: assert property ( // RQ5
    clk_en && !sfr_rd |=> !sfr_rd_valid_q)
    else $error("read answer without a strobe");

  AST_RD_HOLD: assert property ( // RQ6
    clk_en && !sfr_rd |=> $stable(sfr_rdata_q))
    else $error("read data moved without a read");

  AST_ANALOG_READ: assert property ( // RQ8
    s_rd_any ##0 hit_analog |=> sfr_rdata_q == $past(analog_level_q))
    else $error("analog port read not pin level");

  // Ports above the bus pins never take a strap pattern
  AST_UPPER_RESET: assert property ( // RQ18
    s_reset_cycle |=> dir_w[NP-1:5] == '0 && alt_w[NP-1:5] == '0)
    else $error("non-bus port not cleared by reset");

  // Clock enable low must freeze every register
  AST_FREEZE: assert property (
    !clk_en |=>
      $stable(latch_w) && $stable(dir_w) && $stable(alt_w) &&
      $stable(pad_oe) && $stable(sys_reset_q))
    else $error("state moved with clock enable low");

  AST_UNIMPL: assert property ( // RQ14
    latch_w[3][7:4] == 4'h0 && dir_w[11][7:4] == 4'h0 &&
    alt_w[3][7:4] == 4'h0)
    else $error("unimplemented bits hold ones");

  // One write check per port register, unimplemented bits masked
  for (genvar k = 0; k < NP; k++) begin : g_chk
    AST_WRITE_LATCH_K: assert property ( // RQ7
      @(posedge core_clk) disable iff (!arst_n)
      run && sfr_wr && hit_latch_w[k] |=>
        latch_w[k] == $past(sfr_wdata & pcb_pkg::PCB_IMPL[k]))
      else $error("latch write lost bits");

    AST_WRITE_DIR_K: assert property ( // RQ13
      @(posedge core_clk) disable iff (!arst_n)
      run && sfr_wr && hit_dir_w[k] |=>
        dir_w[k] == $past(sfr_wdata & pcb_pkg::PCB_IMPL[k]))
      else $error("direction write lost bits");

    AST_WRITE_ALT_K: assert property ( // RQ15
      @(posedge core_clk) disable iff (!arst_n)
      run && sfr_wr && hit_alt_w[k] |=>
        alt_w[k] == $past(sfr_wdata & pcb_pkg::PCB_IMPL[k]))
      else $error("alternate write lost bits");
  end

endmodule
`default_nettype wire

//--- testbench/pcb_pin_model.sv
// Pin level model: pad drivers, pull-ups and an external source
`timescale 1ns/1ps
`default_nettype none
module pcb_pin_model (
  input  wire logic [13:0][7:0] pad_out,
  input  wire logic [13:0][7:0] pad_oe,
  input  wire logic [13:0][7:0] pad_pullup,
  input  wire logic [13:0][7:0] ext_val,
  input  wire logic [13:0][7:0] ext_en,
  output logic      [13:0][7:0] pad_in
);
  // Floating pins read one where pulled up, else the inverse of the source, never a held level
  assign pad_in = (pad_oe & pad_out)
    | (~pad_oe & ext_en & ext_val)
    | (~pad_oe & ~ext_en & (pad_pullup | ~ext_val));
endmodule
`default_nettype wire

//--- testbench/pcb_port_bank_tb.sv
// Register and pin tests of the port control bank
`timescale 1ns/1ps
`default_nettype none
module pcb_port_bank_tb;
  // Port 8 bit 0 has no alternate source
  localparam logic [13:0][7:0] ALT_P = {{5{8'hFF}}, 8'hFE, {8{8'hFF}}};
  logic             core_clk, arst_n, clk_en, reset_pin_n;
  logic             break_instruction, watchdog_overflow, opcode_trap;
  logic             external_access_strap_n, sfr_wr, sfr_rd;
  logic             sfr_rd_valid_q, sys_reset_q;
  logic [15:0]      sfr_addr;
  logic [7:0]       sfr_wdata, sfr_rdata_q, analog_pad_in;
  logic [13:0][7:0] pad_in, pad_out, pad_oe, pad_pullup;
  logic [13:0][7:0] alt_out_data, alt_in_data, ext_val, ext_en;
  int               n_mismatch = 0;
  int               compares = 0;

  pcb_port_bank #(.ALT_PRESENT(ALT_P)) pcb_port_bank_i (
    .core_clk, .arst_n, .clk_en, .reset_pin_n, .break_instruction,
    .watchdog_overflow, .opcode_trap, .external_access_strap_n,
    .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata_q,
    .sfr_rd_valid_q, .sys_reset_q, .pad_in, .pad_out, .pad_oe,
    .pad_pullup, .alt_out_data, .alt_in_data, .analog_pad_in);

  pcb_pin_model pcb_pin_model_i (
    .pad_out, .pad_oe, .pad_pullup, .ext_val, .ext_en, .pad_in);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic final_report();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge core_clk);
    sfr_wr    <= 1'b0;
  endtask

  // Waits for the read strobe answer under a small bound
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    int n;
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge core_clk);
    sfr_rd   <= 1'b0;
    n = 0;
    #1;
    while (sfr_rd_valid_q !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (sfr_rd_valid_q !== 1'b1) begin
      n_mismatch++;
      $display("Error t=%0t valid=%h exp=%h", $time, sfr_rd_valid_q, 1'b1);
    end
    chk(sfr_rdata_q, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  initial begin
    #60000;
    n_mismatch++;
    final_report();
  end

  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    reset_pin_n = 1'b1;
    break_instruction = 1'b0;
    watchdog_overflow = 1'b0;
    opcode_trap = 1'b0;
    external_access_strap_n = 1'b1;
    sfr_addr = 16'h0000;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    analog_pad_in = 8'h96;
    alt_out_data = '0;
    ext_val = '0;
    ext_en = '1;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    cyc(4);
    for (int i = 0; i < 14; i++) begin
      rdc(pcb_pkg::PCB_DIR_ADDR[i], 8'h00);
      rdc(pcb_pkg::PCB_ALT_ADDR[i], 8'h00);
    end
    wr(16'h0025, 8'hFF);
    rdc(16'h001D, 8'h00);
    wr(16'h001D, 8'hA5);
    rdc(16'h001D, 8'hA5);
    cyc(2);
    chk(pad_out[5], 8'hA5);
    chk(pad_oe[5], 8'hFF);
    wr(16'h0023, 8'hFF);
    rdc(16'h0023, 8'h0F);
    // Mixed direction on port 6
    @(posedge core_clk);
    ext_val[6] <= 8'hC3;
    wr(16'h0026, 8'h0F);
    wr(16'h001E, 8'h5A);
    cyc(3);
    chk(pad_oe[6], 8'h0F);
    rdc(16'h001E, 8'hCA);
    wr(16'h0026, 8'hFF);
    rdc(16'h001E, 8'h5A);
    wr(16'h0026, 8'h0F);
    cyc(3);
    rdc(16'h001E, 8'hCA);
    wr(16'h001E, 8'hCA);
    wr(16'h0026, 8'hFF);
    rdc(16'h001E, 8'hCA);
    // Alternate output and pull-up on port 7
    @(posedge core_clk);
    alt_out_data[7] <= 8'h33;
    wr(16'h0027, 8'hFF);
    wr(16'h002F, 8'h0F);
    wr(16'h001F, 8'hCC);
    rdc(16'h001F, 8'hC3);
    cyc(2);
    chk(pad_out[7], 8'hC3);
    wr(16'h0027, 8'h00);
    wr(16'h002F, 8'hF0);
    @(posedge core_clk);
    ext_en[7]  <= 8'h00;
    ext_val[7] <= 8'hFF;
    cyc(4);
    chk(pad_pullup[7], 8'hF0);
    chk(pad_oe[7], 8'h00);
    chk(alt_in_data[7], 8'hF0);
    rdc(16'h001F, 8'hF0);
    @(posedge core_clk);
    alt_out_data[8] <= 8'hFF;
    wr(16'h00C0, 8'h03);
    wr(16'h00C8, 8'h03);
    cyc(2);
    chk(pad_out[8] & 8'h03, 8'h02);
    rdc(16'h00BC, 8'h96);
    wr(16'h00BC, 8'h00);
    rdc(16'h00BC, 8'h96);
    rdc(16'h00AA, 8'h00);
    // Each reset source in turn
    for (int s = 0; s < 4; s++) begin
      wr(16'h0025, 8'hFF);
      wr(16'h001D, 8'h3C);
      @(posedge core_clk);
      break_instruction <= (s == 0);
      watchdog_overflow <= (s == 1);
      opcode_trap       <= (s == 2);
      reset_pin_n       <= (s != 3);
      repeat (3) @(posedge core_clk);
      break_instruction <= 1'b0;
      watchdog_overflow <= 1'b0;
      opcode_trap       <= 1'b0;
      reset_pin_n       <= 1'b1;
      cyc(8);
      rdc(16'h0025, 8'h00);
      wr(16'h0025, 8'hFF);
      rdc(16'h001D, 8'h00);
    end
    // Strap low: bus pins come up as alternate outputs
    @(posedge core_clk);
    external_access_strap_n <= 1'b0;
    alt_out_data[0] <= 8'h69;
    ext_val[0] <= 8'h3C;
    reset_pin_n <= 1'b0;
    arst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    reset_pin_n <= 1'b1;
    cyc(8);
    for (int i = 0; i < 5; i++) begin
      rdc(pcb_pkg::PCB_DIR_ADDR[i], pcb_pkg::PCB_DIR_EXT[i]);
      rdc(pcb_pkg::PCB_ALT_ADDR[i], pcb_pkg::PCB_ALT_EXT[i]);
    end
    chk(pad_oe[0], 8'hFF);
    rdc(16'h0025, 8'h00);
    rdc(16'h00C4, 8'h00);
    rdc(16'h00C6, 8'h00);
    // Port 0 through alternate, latch, frozen write and pin reads
    rdc(16'h0018, 8'h69);
    wr(16'h0018, 8'hA5);
    wr(16'h0028, 8'h00);
    rdc(16'h0018, 8'hA5);
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(16'h0018, 8'h11);
    clk_en <= 1'b1;
    rdc(16'h0018, 8'hA5);
    wr(16'h0020, 8'h00);
    cyc(4);
    rdc(16'h0018, 8'h3C);
    final_report();
  end
endmodule
`default_nettype wire
